//--- common/spcu_pkg.sv
// Constants, types and state codes of the serial programmer command unit.
// Assumes one 200 MHz clock and a byte layer that delivers whole command bytes.
// Operation
// RULE1 - Write command: code, address, size, then data
// RULE2 - Size zero means whole flash size
// RULE3 - Oversized write length clamps to flash size
// RULE4 - Write data dropped while controller locked
// RULE5 - Write data dropped for protected regions
// RULE6 - Read command: code, address, size, data back
// RULE7 - Protected main memory reads return FFH
// RULE8 - CRC command returns CRC-CCITT, high byte first
// RULE9 - Outside programming mode CRC returns FFFFH
// RULE10 - CRC reply follows one clock per byte; code takes a flash req/ack round trip, at least two clocks, per byte
// RULE11 - Autobaud read: zero nibble, then low byte
// RULE12 - F0H loads test register, F1H reads it
// RULE13 - Control bit 7 selects flash control mode
// RULE14 - Status bit 7 shows flash control mode
// RULE15 - Status bit 6 mirrors partial protect option
// RULE16 - Status bit 5 mirrors full protect option
// RULE17 - Status bit 3 shows operation in progress
// RULE18 - Host waits for idle before new operation
// RULE19 - Test bit 2 selects controller bypass mode
// RULE20 - Test register reachable only by its commands
// RULE21 - Reserved test bits read back as zero
// RULE22 - Power-on with pin high or brownout exits
// RULE23 - Full protect blocks all writes, partial lower; code: in the info area either option blocks writes only from 00C0H up
// RULE24 - Full protect blocks main reads, partial lower
// RULE25 - Address steps by one per data byte
package spcu_pkg;

  // Command codes.
  localparam logic [7:0] CMD_RD_STATUS = 8'h02;
  localparam logic [7:0] CMD_WR_CTRL = 8'h04;
  localparam logic [7:0] CMD_RD_CTRL = 8'h05;
  localparam logic [7:0] CMD_WR_FLASH = 8'h0A;
  localparam logic [7:0] CMD_RD_FLASH = 8'h0B;
  localparam logic [7:0] CMD_CRC = 8'h0E;
  localparam logic [7:0] CMD_RD_BAUD = 8'h1B;
  localparam logic [7:0] CMD_WR_TEST = 8'hF0;
  localparam logic [7:0] CMD_RD_TEST = 8'hF1;

  // Field positions.
  localparam int CTRL_FLASH_CONTROL_MODE_BIT_BIT = 7;
  localparam int STAT_FLASH_CONTROL_MODE_BIT_BIT = 7;
  localparam int STAT_PARTIAL_BIT = 6;
  localparam int STAT_FULL_BIT = 5;
  localparam int STAT_BUSY_BIT = 3;
  localparam int TEST_BYPASS_BIT = 2;

  // Reset values and fixed answers.
  localparam logic CTRL_RESET = 1'h0;
  localparam logic TEST_RESET = 1'h0;
  localparam logic [7:0] PROT_FILL = 8'hFF;
  localparam logic [15:0] CRC_NOT_PROG = 16'hFFFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] INFO_PAGE3_BASE = 16'h00C0;
  localparam int KB_BYTES = 1024;
  localparam int MEM_KB_DEFAULT = 64;
  localparam int REPLY_FIFO_DEPTH = 8;

  // Command sequencer states, one-hot.
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ARGS = 9'h002,
    S_WDATA = 9'h004,
    S_WFLASH = 9'h008,
    S_RFLASH = 9'h010,
    S_RPUSH = 9'h020,
    S_CRC = 9'h040,
    S_SEND = 9'h080,
    S_REGWR = 9'h100
  } spcu_state_t;

  // One byte access toward the flash controller.
  typedef struct packed {
    logic req;
    logic we;
    logic info;
    logic [15:0] addr;
    logic [7:0] wdata;
  } spcu_flash_req_t;

endpackage

//--- hw/spcu_top.sv
// Command unit of the one-pin serial programming port, with its reply FIFO.
// Assumes a same-clock byte layer on both sides and a req/ack flash port.

////////////////////////////////////////////////////////////////////////////////

// Reply FIFO: holds bytes on their way back to the host.
module spcu_fifo import spcu_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = REPLY_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two so the pointers wrap by themselves.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("spcu_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage words.
  logic [AW-1:0] wr_ptr_ff; // Next slot to fill.
  logic [AW-1:0] rd_ptr_ff; // Next slot to drain.
  logic [AW:0] count_ff; // Words held.
  logic push;
  logic pop;

  // Full and empty come straight from the count.
  assign in_ready = (count_ff != (AW + 1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // Storage is written only on an accepted push.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule // spcu_fifo

////////////////////////////////////////////////////////////////////////////////

// Command interpreter top.
module spcu_top import spcu_pkg::*; #(
  parameter int MEM_KB = MEM_KB_DEFAULT
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Command bytes from the serial byte layer.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Reply bytes toward the serial byte layer.
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Flash controller port.
  output spcu_flash_req_t flash_req,
  input wire logic flash_ack,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_unlocked,
  input wire logic flash_busy,
  input wire logic info_area_sel,
  // Option byte one shadow bits, low means enabled.
  input wire logic partial_protect_option,
  input wire logic full_protect_option,
  // Autobaud result and programming mode entry.
  input wire logic [11:0] autobaud_value,
  input wire logic prog_enter,
  // Asynchronous exit conditions.
  input wire logic por_active,
  input wire logic mode_select_port_pin,
  input wire logic brownout_reset,
  // Mode outputs.
  output logic prog_mode,
  output logic flash_control_mode_bit,
  output logic bypass_mode
);
  localparam logic [16:0] MEM_SIZE = 17'(MEM_KB * KB_BYTES);
  localparam logic [15:0] MEM_HALF = 16'(MEM_KB * KB_BYTES / 2);

  // Only the two product flash sizes are served.
  if (MEM_KB != 32 && MEM_KB != 64) begin : g_chk
    $error("spcu_top: MEM_KB must be 32 or 64");
  end

  spcu_state_t state_ff; // Sequencer state.
  logic [7:0] cmd_ff; // Command being served.
  logic [1:0] arg_idx_ff; // Argument byte index.
  logic [7:0] size_hi_ff; // Size high byte.
  logic [15:0] addr_ff; // Flash address.
  logic [16:0] cnt_ff; // Bytes left.
  logic [15:0] resp_ff; // Reply word.
  logic two_ff; // High reply byte still to send.
  logic [15:0] crc_ff; // Running CRC.
  spcu_flash_req_t req_ff; // Flash access.
  logic ctrl_ff; // Flash control mode.
  logic test_ff; // Controller bypass mode.
  logic prog_ff; // Programming mode.
  logic low_seen_ff; // Pin seen low during power-on.
  logic por_d_ff; // Power-on level, delayed.
  logic [2:0] sync1_ff; // First synchroniser stage.
  logic [2:0] sync2_ff; // Second synchroniser stage.
  logic rx_take;
  logic push_valid;
  logic push_ready;
  logic [7:0] push_data;
  logic [7:0] status_rd;
  logic [7:0] test_rd;
  logic [16:0] size_req;
  logic [16:0] size_eff;
  logic last;
  logic full_en;
  logic part_en;
  logic wr_blk;
  logic rd_blk;
  logic [15:0] crc_nxt;

  // Byte-wise CRC-CCITT step, message bits taken most significant first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  // Pins from outside the clock domain pass two flip-flops first.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {brownout_reset, mode_select_port_pin, por_active};
      sync2_ff <= sync1_ff;
    end
  end

  // Programming mode: entered on request, left on brownout or on a power-on
  // during which the mode pin never dropped.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_ff <= 1'b0;
      low_seen_ff <= 1'b0;
      por_d_ff <= 1'b0;
    end else begin
      por_d_ff <= sync2_ff[0];
      if (sync2_ff[0] && !sync2_ff[1]) begin
        low_seen_ff <= 1'b1;
      end else if (!sync2_ff[0]) begin
        low_seen_ff <= 1'b0;
      end
      if (sync2_ff[2]) begin
        prog_ff <= 1'b0; // see RULE22
      end else if (por_d_ff && !sync2_ff[0] && !low_seen_ff) begin
        prog_ff <= 1'b0; // see RULE22
      end else if (prog_enter) begin
        prog_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Protection decode; option bits are enabled when low.
  always_comb begin
    full_en = ~full_protect_option;
    part_en = ~partial_protect_option;
    if (info_area_sel) begin
      wr_blk = (addr_ff >= INFO_PAGE3_BASE) & (full_en | part_en); // see RULE23
      rd_blk = 1'b0;
    end else begin
      wr_blk = full_en | (part_en & (addr_ff < MEM_HALF)); // see RULE23
      rd_blk = full_en | (part_en & (addr_ff < MEM_HALF)); // see RULE24
    end
  end

  // Register read views; reserved bits read as zero.
  always_comb begin
    status_rd = '0;
    status_rd[STAT_FLASH_CONTROL_MODE_BIT_BIT] = ctrl_ff; // see RULE14
    status_rd[STAT_PARTIAL_BIT] = partial_protect_option; // see RULE15
    status_rd[STAT_FULL_BIT] = full_protect_option; // see RULE16
    status_rd[STAT_BUSY_BIT] = flash_busy; // see RULE17
    test_rd = '0;
    test_rd[TEST_BYPASS_BIT] = test_ff; // see RULE21
  end

  // Size decode: zero and oversize both mean the whole flash.
  assign size_req = {1'b0, size_hi_ff, rx_data};
  assign size_eff = (size_req == '0 || size_req > MEM_SIZE) ? MEM_SIZE : size_req; // see RULE2
  assign last = (cnt_ff == 17'h00001);
  assign crc_nxt = crc_step(crc_ff, flash_rdata);

  // Handshakes toward the byte layer and the reply FIFO.
  assign rx_ready = (state_ff == S_IDLE) | (state_ff == S_ARGS) |
                    (state_ff == S_WDATA) | (state_ff == S_REGWR);
  assign rx_take = rx_valid & rx_ready;
  assign push_valid = (state_ff == S_SEND) | (state_ff == S_RPUSH);
  assign push_data = (state_ff == S_SEND && two_ff) ? resp_ff[15:8] : resp_ff[7:0];

  //////////////////////////////////////////////////////////////////////////////

  // Control and test registers, written only by their own commands.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
      test_ff <= TEST_RESET;
    end else if (state_ff == S_REGWR && rx_take) begin
      if (cmd_ff == CMD_WR_CTRL) begin
        ctrl_ff <= rx_data[CTRL_FLASH_CONTROL_MODE_BIT_BIT]; // see RULE13
      end else begin
        test_ff <= rx_data[TEST_BYPASS_BIT]; // see RULE12 see RULE19 see RULE20
      end
    end
  end

  // Command sequencer and transfer datapath.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      cmd_ff <= '0;
      arg_idx_ff <= '0;
      size_hi_ff <= '0;
      addr_ff <= '0;
      cnt_ff <= '0;
      resp_ff <= '0;
      two_ff <= 1'b0;
      crc_ff <= CRC_INIT;
      req_ff <= '0;
    end else begin
      unique case (state_ff)
        // Decode the command byte.
        S_IDLE: begin
          if (rx_take) begin
            cmd_ff <= rx_data;
            arg_idx_ff <= '0;
            two_ff <= 1'b0;
            if (rx_data == CMD_RD_STATUS) begin
              resp_ff <= {8'h00, status_rd};
              state_ff <= S_SEND;
            end else if (rx_data == CMD_RD_CTRL) begin
              resp_ff <= {8'h00, ctrl_ff, 7'h00};
              state_ff <= S_SEND;
            end else if (rx_data == CMD_WR_CTRL || rx_data == CMD_WR_TEST) begin
              state_ff <= S_REGWR;
            end else if (rx_data == CMD_WR_FLASH || rx_data == CMD_RD_FLASH) begin
              state_ff <= S_ARGS; // see RULE1 see RULE6
            end else if (rx_data == CMD_CRC) begin
              two_ff <= 1'b1;
              resp_ff <= CRC_NOT_PROG; // see RULE9
              addr_ff <= '0;
              cnt_ff <= MEM_SIZE;
              crc_ff <= CRC_INIT;
              state_ff <= prog_ff ? S_CRC : S_SEND;
            end else if (rx_data == CMD_RD_BAUD) begin
              two_ff <= 1'b1;
              resp_ff <= {4'h0, autobaud_value}; // see RULE11
              state_ff <= S_SEND;
            end else if (rx_data == CMD_RD_TEST) begin
              resp_ff <= {8'h00, test_rd}; // see RULE12
              state_ff <= S_SEND;
            end
          end
        end
        // Address high, address low, size high, size low.
        S_ARGS: begin
          if (rx_take) begin
            arg_idx_ff <= arg_idx_ff + 2'h1;
            unique case (arg_idx_ff)
              2'h0: addr_ff[15:8] <= rx_data;
              2'h1: addr_ff[7:0] <= rx_data;
              2'h2: size_hi_ff <= rx_data;
              default: begin
                cnt_ff <= size_eff; // see RULE2 see RULE3
                state_ff <= (cmd_ff == CMD_WR_FLASH) ? S_WDATA : S_RFLASH;
              end
            endcase
          end
        end
        // Take one write byte; drop it when locked or protected.
        S_WDATA: begin
          if (rx_take) begin
            if (flash_unlocked && ctrl_ff && !wr_blk) begin
              req_ff <= '{req: 1'b1, we: 1'b1, info: info_area_sel,
                          addr: addr_ff, wdata: rx_data};
              state_ff <= S_WFLASH;
            end else begin
              addr_ff <= addr_ff + 16'h0001; // see RULE4 see RULE5
              cnt_ff <= cnt_ff - 17'h00001;
              state_ff <= last ? S_IDLE : S_WDATA;
            end
          end
        end
        // Hold the write until the controller answers.
        S_WFLASH: begin
          if (flash_ack) begin
            req_ff.req <= 1'b0;
            addr_ff <= addr_ff + 16'h0001; // see RULE25
            cnt_ff <= cnt_ff - 17'h00001;
            state_ff <= last ? S_IDLE : S_WDATA;
          end
        end
        // Fetch one read byte, or fill it when protected.
        S_RFLASH: begin
          if (rd_blk || !ctrl_ff) begin
            resp_ff <= {8'h00, PROT_FILL}; // see RULE7
            state_ff <= S_RPUSH;
          end else if (!req_ff.req) begin
            req_ff <= '{req: 1'b1, we: 1'b0, info: info_area_sel,
                        addr: addr_ff, wdata: 8'h00};
          end else if (flash_ack) begin
            req_ff.req <= 1'b0;
            resp_ff <= {8'h00, flash_rdata};
            state_ff <= S_RPUSH;
          end
        end
        // Queue the read byte and step on.
        S_RPUSH: begin
          if (push_ready) begin
            addr_ff <= addr_ff + 16'h0001; // see RULE25
            cnt_ff <= cnt_ff - 17'h00001;
            state_ff <= last ? S_IDLE : S_RFLASH;
          end
        end
        // Walk the whole main memory, one byte per answer.
        S_CRC: begin
          if (!req_ff.req) begin
            req_ff <= '{req: 1'b1, we: 1'b0, info: 1'b0, addr: addr_ff, wdata: 8'h00};
          end else if (flash_ack) begin
            req_ff.req <= 1'b0;
            crc_ff <= crc_nxt; // see RULE8
            addr_ff <= addr_ff + 16'h0001;
            cnt_ff <= cnt_ff - 17'h00001;
            if (last) begin
              resp_ff <= crc_nxt; // see RULE10
              state_ff <= S_SEND;
            end
          end
        end
        // Queue one or two reply bytes, high byte first.
        S_SEND: begin
          if (push_ready) begin
            two_ff <= 1'b0;
            state_ff <= two_ff ? S_SEND : S_IDLE;
          end
        end
        // Wait for the data byte of a register write.
        S_REGWR: begin
          if (rx_take) begin
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Reply FIFO; a full FIFO stalls the sequencer.
  spcu_fifo #(.WIDTH(8), .DEPTH(REPLY_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  assign flash_req = req_ff;
  assign prog_mode = prog_ff;
  assign flash_control_mode_bit = ctrl_ff;
  assign bypass_mode = test_ff;

  //////////////////////////////////////////////////////////////////////////////

  // Checks on the sequencer.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  zero_size_a: assert property ( // see RULE2
    state_ff == S_ARGS && arg_idx_ff == 2'h3 && rx_take && size_req == '0
    |=> cnt_ff == MEM_SIZE) else $error("zero size not whole flash");
  size_clamp_a: assert property ( // see RULE3
    state_ff == S_ARGS && arg_idx_ff == 2'h3 && rx_take && size_req > MEM_SIZE
    |=> cnt_ff == MEM_SIZE) else $error("oversize not clamped");
  locked_drop_a: assert property ( // see RULE4
    state_ff == S_WDATA && rx_take && !flash_unlocked
    |=> !flash_req.req && state_ff != S_WFLASH) else $error("locked write issued");
  protect_drop_a: assert property ( // see RULE5
    state_ff == S_WDATA && rx_take && wr_blk |=> !flash_req.req)
    else $error("protected write issued");
  protect_fill_a: assert property ( // see RULE7
    state_ff == S_RFLASH && rd_blk |=> state_ff == S_RPUSH && resp_ff[7:0] == PROT_FILL)
    else $error("protected read not filled");
  crc_idle_a: assert property ( // see RULE9
    state_ff == S_IDLE && rx_take && rx_data == CMD_CRC && !prog_ff
    |=> state_ff == S_SEND && resp_ff == CRC_NOT_PROG) else $error("bad CRC outside mode");
  baud_reply_a: assert property ( // see RULE11
    state_ff == S_IDLE && rx_take && rx_data == CMD_RD_BAUD
    |=> resp_ff[15:12] == 4'h0 && resp_ff[11:0] == $past(autobaud_value))
    else $error("bad autobaud reply");
  test_write_a: assert property ( // see RULE19
    state_ff == S_REGWR && cmd_ff == CMD_WR_TEST && rx_take
    |=> bypass_mode == $past(rx_data[TEST_BYPASS_BIT]) ##1 $stable(bypass_mode))
    else $error("bypass bit not loaded");
  ctrl_write_a: assert property ( // see RULE14
    state_ff == S_REGWR && cmd_ff == CMD_WR_CTRL && rx_take
    |=> status_rd[STAT_FLASH_CONTROL_MODE_BIT_BIT] == $past(rx_data[CTRL_FLASH_CONTROL_MODE_BIT_BIT]))
    else $error("status bit 7 not tracking control");
  addr_step_a: assert property ( // see RULE25
    state_ff == S_RPUSH && push_ready |=> addr_ff == $past(addr_ff) + 16'h0001)
    else $error("address did not step");
  brownout_exit_a: assert property ( // see RULE22
    sync2_ff[2] |=> !prog_mode) else $error("brownout did not exit mode");

  write_done_c: cover property (state_ff == S_WFLASH && flash_ack && last);
  read_done_c: cover property (state_ff == S_RPUSH && push_ready && last);
  crc_done_c: cover property (state_ff == S_CRC && flash_ack && last);
  fifo_full_c: cover property (push_valid && !push_ready);
endmodule // spcu_top

//--- sim/spcu_flash_model.sv
// Behavioural flash controller that answers the command unit's byte accesses.
// Assumes the req/ack flash port of spcu_top; content is a fixed function of address.
module spcu_flash_model import spcu_pkg::*; (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Access port.
  input wire spcu_flash_req_t flash_req,
  output logic flash_ack,
  output logic [7:0] flash_rdata,
  // Write log for the bench.
  output int n_wr,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff; // Extra cycles still to wait before answering.
  logic [7:0] pat; // Content of the addressed byte.
  assign pat = flash_req.addr[7:0] ^ flash_req.addr[15:8] ^ 8'hA5;
  // Outside an answer the lines carry the inverse, so a late sample never matches.
  assign flash_rdata = flash_ack ? pat : ~pat;
  // Answers after zero to two extra cycles and logs every write taken.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_ack <= 1'b0;
      wait_ff <= 2'h0;
      n_wr <= 0;
      wr_addr <= 16'h0;
      wr_data <= 8'h0;
    end else begin
      flash_ack <= 1'b0;
      if (flash_req.req && !flash_ack) begin
        if (wait_ff == 2'h0) begin
          flash_ack <= 1'b1;
          wait_ff <= 2'($urandom_range(2));
          if (flash_req.we) begin
            n_wr <= n_wr + 1;
            wr_addr <= flash_req.addr;
            wr_data <= flash_req.wdata;
          end
        end else begin
          wait_ff <= wait_ff - 2'h1;
        end
      end
    end
  end
endmodule // spcu_flash_model

//--- sim/tb.sv
// Self-checking bench of the serial programmer command unit.
// Assumes spcu_flash_model on the flash port and a 32 KB flash.
module tb import spcu_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, tx_ready = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic flash_unlocked = 1'b1, flash_busy = 1'b0, info_area_sel = 1'b0;
  logic partial_protect_option = 1'b1, full_protect_option = 1'b1;
  logic [11:0] autobaud_value = 12'h000;
  logic prog_enter = 1'b0, por_active = 1'b0, mode_select_port_pin = 1'b0;
  logic brownout_reset = 1'b0;
  logic rx_ready, tx_valid, flash_ack, prog_mode, flash_control_mode_bit, bypass_mode;
  logic [7:0] tx_data, flash_rdata, wr_data;
  logic [15:0] wr_addr;
  spcu_flash_req_t flash_req;
  int n_wr, n_errors = 0, checks = 0;
  logic [7:0] exp_q[$]; // Reply bytes still expected, oldest first.

  spcu_top #(.MEM_KB(32)) spcu_top_inst (.ref_clk, .rst_n, .rx_valid, .rx_data, .rx_ready,
    .tx_valid, .tx_ready, .tx_data, .flash_req, .flash_ack, .flash_rdata, .flash_unlocked,
    .flash_busy, .info_area_sel, .partial_protect_option, .full_protect_option,
    .autobaud_value, .prog_enter, .por_active, .mode_select_port_pin, .brownout_reset,
    .prog_mode, .flash_control_mode_bit, .bypass_mode);
  spcu_flash_model spcu_flash_model_inst (.ref_clk, .rst_n, .flash_req, .flash_ack,
    .flash_rdata, .n_wr, .wr_addr, .wr_data);

  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    complete_run();
  endtask
  // Offers one byte at a falling edge and holds it until it is taken.
  task automatic send(input logic [7:0] b);
    int i;
    rx_valid = 1'b1;
    rx_data = b;
    for (i = 0; i < 3000 && rx_ready !== 1'b1; i++) @(negedge ref_clk);
    if (rx_ready !== 1'b1) hang();
    @(negedge ref_clk);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] a, input logic [15:0] s);
    send(c);
    send(a[15:8]);
    send(a[7:0]);
    send(s[15:8]);
    send(s[7:0]);
  endtask
  // Releases the byte line and waits until every expected reply has left.
  task automatic idle();
    int i;
    rx_valid = 1'b0;
    for (i = 0; i < 3000 && exp_q.size() > 0; i++) @(negedge ref_clk);
    if (exp_q.size() > 0) hang();
    @(negedge ref_clk);
  endtask
  task automatic mode_wait(input logic v);
    int i;
    for (i = 0; i < 40 && prog_mode !== v; i++) @(negedge ref_clk);
    chk(prog_mode, v);
  endtask
  function automatic logic [7:0] fdat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  // Stalls the reply side at random and checks each byte that will be popped.
  always @(negedge ref_clk) begin
    tx_ready = 1'($urandom);
    if (rst_n && tx_valid === 1'b1 && tx_ready) begin
      // An unexpected byte is compared with a value it can never have.
      if (exp_q.size() == 0) chk(tx_data, 24'h100);
      else chk(tx_data, exp_q.pop_front());
    end
  end

  initial begin
    int i, c;
    logic [15:0] a;
    logic [11:0] v;
    i = $urandom(32'h36D4);
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    partial_protect_option = 1'($urandom);
    full_protect_option = 1'($urandom);
    flash_busy = 1'($urandom);
    exp_q.push_back({1'b0, partial_protect_option, full_protect_option, 1'b0,
      flash_busy, 3'h0});
    send(CMD_RD_STATUS);
    partial_protect_option = 1'b0;
    full_protect_option = 1'b1;
    flash_busy = 1'b1;
    exp_q.push_back(8'h28);
    send(CMD_RD_STATUS);
    exp_q.push_back(8'h00);
    send(CMD_RD_CTRL);
    send(CMD_WR_CTRL);
    send(8'hFF);
    flash_busy = 1'b0;
    exp_q.push_back(8'h80);
    exp_q.push_back(8'hA0);
    send(CMD_RD_CTRL);
    send(CMD_RD_STATUS);
    idle();
    chk(flash_control_mode_bit, 1'b1);
    for (i = 0; i < 2; i++) begin
      send(CMD_WR_TEST);
      send(i == 0 ? 8'hFF : 8'hFB);
      exp_q.push_back(i == 0 ? 8'h04 : 8'h00);
      send(CMD_RD_TEST);
      idle();
      chk(bypass_mode, i == 0);
    end
    v = 12'($urandom);
    autobaud_value = v;
    exp_q.push_back({4'h0, v[11:8]});
    exp_q.push_back(v[7:0]);
    exp_q.push_back(8'hFF);
    exp_q.push_back(8'hFF);
    send(CMD_RD_BAUD);
    send(CMD_CRC);
    a = 16'h4000 + 16'($urandom_range(255));
    for (i = 0; i < 3; i++) exp_q.push_back(fdat(a + 16'(i)));
    cmd(CMD_RD_FLASH, a, 16'h0003);
    exp_q.push_back(8'hFF);
    exp_q.push_back(fdat(16'h4000));
    cmd(CMD_RD_FLASH, 16'h3FFF, 16'h0002);
    idle();
    full_protect_option = 1'b0;
    exp_q.push_back(8'hFF);
    cmd(CMD_RD_FLASH, a, 16'h0001);
    idle();
    full_protect_option = 1'b1;
    for (i = 0; i < 4; i++) begin
      a = (i == 2) ? 16'h1000 : (i == 3) ? 16'h00C0 : 16'h5000;
      flash_unlocked = (i == 0) || (i > 1 && 1'($urandom));
      info_area_sel = (i == 3);
      c = n_wr;
      cmd(CMD_WR_FLASH, a, 16'h0002);
      send(8'h3C);
      send(8'hC3);
      exp_q.push_back(8'hA0);
      send(CMD_RD_STATUS);
      idle();
      chk(24'(n_wr - c), (i == 0) ? 24'h2 : 24'h0);
      if (i == 0) chk({wr_addr, wr_data}, {a + 16'h1, 8'hC3});
    end
    exp_q.push_back(fdat(16'h00C0));
    cmd(CMD_RD_FLASH, 16'h00C0, 16'h0001);
    idle();
    // Zero and oversize writes run long; a reset in mid-transfer cuts them.
    for (i = 0; i < 2; i++) begin
      info_area_sel = 1'($urandom);
      cmd(CMD_WR_FLASH, 16'h1000, (i == 0) ? 16'h0000 : 16'h9000);
      send(8'h11);
      send(8'h22);
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      exp_q.push_back(8'h20);
      send(CMD_RD_STATUS);
      idle();
    end
    for (i = 0; i < 3; i++) begin
      mode_select_port_pin = (i == 0) ? 1'($urandom) : (i == 1);
      prog_enter = 1'b1;
      @(negedge ref_clk);
      prog_enter = 1'b0;
      mode_wait(1'b1);
      brownout_reset = (i == 0);
      por_active = (i > 0);
      repeat (6) @(negedge ref_clk);
      brownout_reset = 1'b0;
      por_active = 1'b0;
      repeat (4) @(negedge ref_clk);
      mode_wait(i == 2);
    end
    complete_run();
  end
endmodule // tb
